// *** design/pvc_pkg.sv ***
// Package of constants and types for the process value conditioning stage
package pvc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_BIAS   = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_FILT   = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_SLOPE  = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_LOWCUT = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_RST1   = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_ERR1   = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_CYC1   = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_RST2   = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_ERR2   = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_CYC2   = 4'ha;
  localparam logic [ADDR_W-1:0] OFF_PV_LO  = 4'hb;
  localparam logic [ADDR_W-1:0] OFF_PV_HI  = 4'hc;
  localparam logic [ADDR_W-1:0] OFF_STAT   = 4'hd;
  // Control register fields
  localparam int CTRL_DP_LSB = 0;
  localparam int CTRL_SHORT  = 3;
  localparam int CTRL_CJ_EXT = 4;
  localparam int CTRL_SQRT   = 5;
  localparam int CTRL_SENSE1 = 6;
  localparam int CTRL_SENSE2 = 7;
  // Decimal point: 1 = xxxx.x up to 4 = x.xxxx
  localparam logic [2:0] DP_MIN = 3'h1;
  localparam logic [2:0] DP_MAX = 3'h4;
  localparam logic [2:0] DP_DEF = 3'h1;
  localparam logic signed [15:0] BIAS_MIN = -16'sd10000;
  localparam logic signed [15:0] BIAS_MAX = 16'sd10000;
  localparam logic [15:0] BIAS_DEF  = 16'h0000;
  localparam logic [6:0]  FILT_MAX  = 7'd100;
  localparam logic [6:0]  FILT_DEF  = 7'd0;
  // Slope in thousandths
  localparam logic [10:0] SLOPE_MIN  = 11'd500;
  localparam logic [10:0] SLOPE_MAX  = 11'd1500;
  localparam logic [10:0] SLOPE_UNIT = 11'd1000;
  // Low cut in tenths of a percent
  localparam logic [5:0]  LOWCUT_MAX = 6'd50;
  localparam logic [5:0]  LOWCUT_DEF = 6'd10;
  localparam int          LOWCUT_CNT = 10;
  // Output levels in tenths of a percent
  localparam logic [9:0]  LVL_FULL = 10'd1000;
  localparam logic [9:0]  LVL_HALF = 10'd500;
  localparam logic [9:0]  LVL_DEF  = 10'd0;
  localparam logic [6:0]  CYC_MIN = 7'd1;
  localparam logic [6:0]  CYC_MAX = 7'd120;
  localparam logic [6:0]  CYC_CONTACT = 7'd30;
  localparam logic [6:0]  CYC_SSR     = 7'd3;
  // Full input span in counts
  localparam int SPAN_CNT = 10000;
  localparam int SAMPLES_PER_S = 10;
  localparam int MS_PER_S = 1000;
  localparam int CLK_HZ = 125000000;

  typedef enum logic [1:0] {
    PVC_IN_RTD = 2'h0,
    PVC_IN_TC  = 2'h1,
    PVC_IN_MV  = 2'h2,
    PVC_IN_MA  = 2'h3
  } pvc_input_type;

  typedef struct packed {
    logic       sense;
    logic [9:0] rst_lvl;
    logic [9:0] err_lvl;
    logic [6:0] cyc;
  } pvc_chan_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } pvc_bus_type;
endpackage

// *** design/pvc_stage.sv ***
// Process value conditioning and control output shaping stage
`timescale 1ns/1ps
`default_nettype none

// Function
// - Decimal point set only for voltage input
// - Normal/short lowest digit, change reinitializes
// - Thermocouple junction compensation internal or external
// - Signed bias within plus/minus ten thousand
// - First-order lag, off or 1..100 s
// - Slope 0.5..1.5 for voltage/current only
// - Process value is input times slope plus bias
// - Slope applies after square-root result
// - Square root only when enabled, linear inputs
// - Low cut only while square root enabled
// - At or below low cut gives zero
// - Reverse or direct deviation sense
// - Sense locked during self tuning
// - Reset state holds reset level
// - On-off reset level snaps full or off
// - Error gives error level, on-off snapped
// - Reset level beats error level
// - Proportioning period 1..120 s, kind default taken after a first 30 s cycle
// - Period locked during tuning or ramp
// - Second channel on two-output variants only
// - Confirmed unit change reinitializes, thermal inputs only
module pvc_stage #(
  parameter int TICKS_PER_MS = 125000
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire pvc_pkg::pvc_bus_type bus,
  output logic [15:0]               rdata,
  input  wire pvc_pkg::pvc_input_type input_class,
  input  wire logic                 has_fraction,
  input  wire logic                 unit_change_confirm,
  input  wire logic                 two_output,
  input  wire logic                 ssr_drive,
  input  wire logic                 self_tuning,
  input  wire logic                 ramp_active,
  input  wire logic                 reset_state,
  input  wire logic                 on_off,
  input  wire logic                 input_error,
  input  wire logic                 sample_valid,
  input  wire logic signed [15:0]   sample,
  input  wire logic signed [31:0]   set_value,
  input  wire logic [9:0]           demand1,
  input  wire logic [9:0]           demand2,
  output logic signed [31:0]        pv,
  output logic signed [31:0]        deviation1,
  output logic signed [31:0]        deviation2,
  output logic [2:0]                dp_pos,
  output logic                      short_digit,
  output logic                      junction_comp_mode,
  output logic                      reinit,
  output logic [9:0]                level1,
  output logic [9:0]                level2,
  output logic                      first_drive_channel,
  output logic                      second_drive_channel
);
  import pvc_pkg::*;

  logic               sqrt_enable;
  logic signed [15:0] bias;
  logic [6:0]         filt;
  logic [10:0]        slope;
  logic [5:0]         lowcut;
  pvc_chan_type       ch1;
  pvc_chan_type       ch2;
  logic               linear_in;
  logic               thermal_in;
  logic               wr_ctrl;
  logic               short_change;
  logic               sqrt_act;
  logic signed [31:0] x_cut;
  logic signed [31:0] x_root;
  logic signed [31:0] x_scaled;
  logic signed [31:0] next_pv;
  logic [16:0]        ms_cnt;
  logic               ms_tick;

  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [31:0] rem;
    logic [31:0] root;
    logic [31:0] bit_v;
    rem = v;
    root = 32'h0;
    bit_v = 32'h40000000;
    for (int i = 0; i < 16; i++) begin
      if (rem >= (root | bit_v)) begin
        rem = rem - (root | bit_v);
        root = (root >> 1) | bit_v;
      end else begin
        root = root >> 1;
      end
      bit_v = bit_v >> 2;
    end
    return root[15:0];
  endfunction

  function automatic logic [9:0] snap(input logic [9:0] lvl, input logic onoff);
    if (!onoff) begin
      return lvl;
    end
    return (lvl >= LVL_HALF) ? LVL_FULL : LVL_DEF;
  endfunction

  function automatic logic [9:0] pick(input pvc_chan_type c, input logic [9:0] dmd,
                                      input logic signed [31:0] dev);
    if (reset_state) begin
      return snap(c.rst_lvl, on_off);
    end
    if (input_error) begin
      return snap(c.err_lvl, on_off);
    end
    if (on_off) begin
      return (dev > 32'sd0) ? LVL_FULL : LVL_DEF;
    end
    return dmd;
  endfunction

  function automatic logic cyc_ok(input logic [15:0] d);
    return d[6:0] >= CYC_MIN && d[6:0] <= CYC_MAX && d[15:7] == 9'h000;
  endfunction

  function automatic logic lvl_ok(input logic [15:0] d);
    return d <= {6'h00, LVL_FULL};
  endfunction

  assign linear_in  = input_class == PVC_IN_MV || input_class == PVC_IN_MA;
  assign thermal_in = !linear_in;
  assign wr_ctrl    = bus.wr && bus.addr == OFF_CTRL;
  assign short_change = wr_ctrl && thermal_in && has_fraction
                        && bus.wdata[CTRL_SHORT] != short_digit;

  // Control register
  always_ff @(posedge clk) begin
    if (reset) begin
      dp_pos <= DP_DEF;
      short_digit <= 1'b0;
      junction_comp_mode <= 1'b0;
      sqrt_enable <= 1'b0;
    end else if (wr_ctrl) begin
      if (input_class == PVC_IN_MV && bus.wdata[CTRL_DP_LSB +: 3] >= DP_MIN
          && bus.wdata[CTRL_DP_LSB +: 3] <= DP_MAX) begin
        dp_pos <= bus.wdata[CTRL_DP_LSB +: 3];
      end
      if (thermal_in && has_fraction) begin
        short_digit <= bus.wdata[CTRL_SHORT];
      end
      junction_comp_mode <= bus.wdata[CTRL_CJ_EXT];
      if (linear_in) begin
        sqrt_enable <= bus.wdata[CTRL_SQRT];
      end
    end
  end

  // Parameters that a reinitialize restores
  always_ff @(posedge clk) begin
    if (reset || reinit) begin
      bias <= BIAS_DEF;
      filt <= FILT_DEF;
    end else if (bus.wr) begin
      if (bus.addr == OFF_BIAS && $signed(bus.wdata) >= BIAS_MIN
          && $signed(bus.wdata) <= BIAS_MAX) begin
        bias <= bus.wdata;
      end
      if (bus.addr == OFF_FILT && bus.wdata <= {9'h000, FILT_MAX}) begin
        filt <= bus.wdata[6:0];
      end
    end
  end

  // Reinitialize pulse on digit change or on unit change confirmed with a thermal input
  always_ff @(posedge clk) begin
    if (reset) begin
      reinit <= 1'b0;
    end else begin
      reinit <= short_change || (unit_change_confirm && thermal_in);
    end
  end

  // Input path settings
  always_ff @(posedge clk) begin
    if (reset) begin
      slope <= SLOPE_UNIT;
      lowcut <= LOWCUT_DEF;
    end else if (bus.wr) begin
      if (bus.addr == OFF_SLOPE && linear_in && bus.wdata >= {5'h00, SLOPE_MIN}
          && bus.wdata <= {5'h00, SLOPE_MAX}) begin
        slope <= bus.wdata[10:0];
      end
      if (bus.addr == OFF_LOWCUT && bus.wdata <= {10'h000, LOWCUT_MAX}) begin
        lowcut <= bus.wdata[5:0];
      end
    end
  end

  // Output channel settings
  always_ff @(posedge clk) begin
    if (reset) begin
      ch1.rst_lvl <= LVL_DEF;
      ch1.err_lvl <= LVL_DEF;
      ch2.rst_lvl <= LVL_DEF;
      ch2.err_lvl <= LVL_DEF;
      ch1.cyc <= ssr_drive ? CYC_SSR : CYC_CONTACT;
      ch2.cyc <= ssr_drive ? CYC_SSR : CYC_CONTACT;
      ch1.sense <= 1'b0;
      ch2.sense <= 1'b1;
    end else if (bus.wr) begin
      if (wr_ctrl && !self_tuning) begin
        ch1.sense <= bus.wdata[CTRL_SENSE1];
        ch2.sense <= bus.wdata[CTRL_SENSE2];
      end
      if (bus.addr == OFF_RST1 && lvl_ok(bus.wdata)) ch1.rst_lvl <= bus.wdata[9:0];
      if (bus.addr == OFF_ERR1 && lvl_ok(bus.wdata)) ch1.err_lvl <= bus.wdata[9:0];
      if (bus.addr == OFF_RST2 && lvl_ok(bus.wdata)) ch2.rst_lvl <= bus.wdata[9:0];
      if (bus.addr == OFF_ERR2 && lvl_ok(bus.wdata)) ch2.err_lvl <= bus.wdata[9:0];
      if (!self_tuning && !ramp_active && cyc_ok(bus.wdata)) begin
        if (bus.addr == OFF_CYC1) ch1.cyc <= bus.wdata[6:0];
        if (bus.addr == OFF_CYC2) ch2.cyc <= bus.wdata[6:0];
      end
    end
  end

  // Read port
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      case (bus.addr)
        OFF_CTRL:   rdata <= {8'h00, ch2.sense, ch1.sense, sqrt_enable,
                              junction_comp_mode, short_digit, dp_pos};
        OFF_BIAS:   rdata <= bias;
        OFF_FILT:   rdata <= {9'h000, filt};
        OFF_SLOPE:  rdata <= {5'h00, slope};
        OFF_LOWCUT: rdata <= {10'h000, lowcut};
        OFF_RST1:   rdata <= {6'h00, ch1.rst_lvl};
        OFF_ERR1:   rdata <= {6'h00, ch1.err_lvl};
        OFF_CYC1:   rdata <= {9'h000, ch1.cyc};
        OFF_RST2:   rdata <= {6'h00, ch2.rst_lvl};
        OFF_ERR2:   rdata <= {6'h00, ch2.err_lvl};
        OFF_CYC2:   rdata <= {9'h000, ch2.cyc};
        OFF_PV_LO:  rdata <= pv[15:0];
        OFF_PV_HI:  rdata <= pv[31:16];
        OFF_STAT:   rdata <= {12'h000, input_error, reset_state, level2 != 10'd0,
                              level1 != 10'd0};
        default:    rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // Conditioning chain
  always_comb begin
    sqrt_act = sqrt_enable && linear_in;
    x_cut = 32'(sample);
    if (sqrt_act && x_cut <= 32'(int'(lowcut) * LOWCUT_CNT)) begin
      x_cut = 32'sd0;
    end
    x_root = sqrt_act ? $signed({16'h0000, isqrt(32'(x_cut * SPAN_CNT))}) : x_cut;
    x_scaled = 32'(x_root * $signed({21'h000000, linear_in ? slope : SLOPE_UNIT})
                   / $signed(32'(SLOPE_UNIT))) + 32'(bias);
    if (filt == FILT_DEF) begin
      next_pv = x_scaled;
    end else begin
      next_pv = pv + (x_scaled - pv) / ($signed(32'(filt)) * SAMPLES_PER_S + 32'sd1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pv <= 32'sd0;
    end else if (sample_valid) begin
      pv <= next_pv;
    end
  end

  // Deviation seen by the controller, signed by sense
  always_ff @(posedge clk) begin
    if (reset) begin
      deviation1 <= 32'sd0;
      deviation2 <= 32'sd0;
    end else begin
      deviation1 <= ch1.sense ? pv - set_value : set_value - pv;
      deviation2 <= ch2.sense ? pv - set_value : set_value - pv;
    end
  end

  // Effective output levels
  always_ff @(posedge clk) begin
    if (reset) begin
      level1 <= LVL_DEF;
      level2 <= LVL_DEF;
    end else begin
      level1 <= pick(ch1, demand1, deviation1);
      level2 <= two_output ? pick(ch2, demand2, deviation2) : LVL_DEF;
    end
  end

  // Millisecond tick
  always_ff @(posedge clk) begin
    if (reset || ms_tick) begin
      ms_cnt <= 17'd0;
    end else begin
      ms_cnt <= ms_cnt + 17'd1;
    end
  end
  assign ms_tick = ms_cnt == 17'(TICKS_PER_MS - 1);

  // Time proportioning per channel
  logic [16:0] pos1;
  logic [16:0] pos2;
  logic [16:0] on1;
  logic [16:0] on2;
  logic [16:0] len1;
  logic [16:0] len2;
  always_ff @(posedge clk) begin
    if (reset) begin
      pos1 <= 17'd0;
      pos2 <= 17'd0;
      on1 <= 17'd0;
      on2 <= 17'd0;
      len1 <= 17'(int'(CYC_CONTACT) * MS_PER_S);
      len2 <= 17'(int'(CYC_CONTACT) * MS_PER_S);
    end else if (ms_tick) begin
      pos1 <= (pos1 + 17'd1 >= len1) ? 17'd0 : pos1 + 17'd1;
      pos2 <= (pos2 + 17'd1 >= len2) ? 17'd0 : pos2 + 17'd1;
      if (pos1 + 17'd1 >= len1) begin
        on1 <= 17'(level1) * 17'(ch1.cyc);
        len1 <= 17'(ch1.cyc * 17'(MS_PER_S));
      end
      if (pos2 + 17'd1 >= len2) begin
        on2 <= 17'(level2) * 17'(ch2.cyc);
        len2 <= 17'(ch2.cyc * 17'(MS_PER_S));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      first_drive_channel <= 1'b0;
      second_drive_channel <= 1'b0;
    end else begin
      first_drive_channel <= pos1 < on1;
      second_drive_channel <= two_output && pos2 < on2;
    end
  end

  property p_reset_level;
    @(posedge clk) disable iff (reset)
      reset_state && !on_off ##1 reset_state |-> level1 == $past(ch1.rst_lvl);
  endproperty
  a_reset_level: assert property (p_reset_level) else $error("reset level not held");

  property p_reset_beats_error;
    @(posedge clk) disable iff (reset)
      reset_state && input_error && on_off && ch1.rst_lvl >= LVL_HALF
      |=> level1 == LVL_FULL;
  endproperty
  a_reset_beats_error: assert property (p_reset_beats_error) else $error("reset not preferred");

  property p_onoff_error;
    @(posedge clk) disable iff (reset)
      !reset_state && input_error && on_off && ch1.err_lvl < LVL_HALF |=> level1 == LVL_DEF;
  endproperty
  a_onoff_error: assert property (p_onoff_error) else $error("error level not snapped");

  property p_sense_locked;
    @(posedge clk) disable iff (reset)
      wr_ctrl && self_tuning |=> ch1.sense == $past(ch1.sense);
  endproperty
  a_sense_locked: assert property (p_sense_locked) else $error("sense changed in tuning");

  property p_cycle_locked;
    @(posedge clk) disable iff (reset)
      bus.wr && bus.addr == OFF_CYC1 && (self_tuning || ramp_active)
      |=> $stable(ch1.cyc);
  endproperty
  a_cycle_locked: assert property (p_cycle_locked) else $error("period changed when locked");

  property p_bias_range;
    @(posedge clk) disable iff (reset) bias >= BIAS_MIN && bias <= BIAS_MAX;
  endproperty
  a_bias_range: assert property (p_bias_range) else $error("bias out of range");

  property p_low_cut;
    @(posedge clk) disable iff (reset)
      sample_valid && sqrt_act && int'(sample) <= int'(lowcut) * LOWCUT_CNT
      && bias == 16'sd0 && filt == FILT_DEF
      |=> pv == 32'sd0;
  endproperty
  a_low_cut: assert property (p_low_cut) else $error("low cut did not zero");

  property p_single_output;
    @(posedge clk) disable iff (reset) !two_output ##1 !two_output |-> !second_drive_channel;
  endproperty
  a_single_output: assert property (p_single_output) else $error("second channel driven");

  property p_reinit;
    @(posedge clk) disable iff (reset) short_change |=> reinit ##1 bias == 16'sd0;
  endproperty
  a_reinit: assert property (p_reinit) else $error("no reinitialize");
endmodule

`default_nettype wire

// *** dv/pvc_sensor_model.sv ***
// Behavioural input converter and drive monitor for the conditioning stage
`timescale 1ns/1ps
`default_nettype none
module pvc_sensor_model (
  input  wire logic               clk,
  input  wire logic               start,
  input  wire logic signed [15:0] value,
  input  wire logic               drive,
  input  wire logic               clr,
  output logic                    sample_valid,
  output logic signed [15:0]      sample,
  output int                      on_cnt
);
  initial begin
    sample_valid = 1'b0;
    sample = 16'h0000;
    on_cnt = 0;
  end
  // Word toggles outside the valid cycle
  always @(posedge clk) begin
    sample_valid <= start;
    sample <= start ? value : ~sample;
  end
  always @(posedge clk) begin
    on_cnt <= clr ? 0 : on_cnt + (drive ? 1 : 0);
  end
endmodule
`default_nettype wire

// *** dv/test_pvc_stage.sv ***
// Self-checking bench for the conditioning and output stage
`timescale 1ns/1ps
`default_nettype none
module test_pvc_stage;
  import pvc_pkg::*;
  logic               clk, reset, has_fraction, ucc, two_output, ssr_drive;
  logic               self_tuning, ramp_active, reset_state, on_off, input_error;
  logic               start, clr, rd_d, sv_d, sample_valid, short_digit, jcm, drv1;
  logic               drv2, rinit;
  logic signed [15:0] value, sample;
  logic signed [31:0] set_value, pv, deviation1, deviation2;
  logic [9:0]         demand1, demand2, level1, lv2;
  logic [15:0]        rdata;
  logic [2:0]         dp_pos;
  logic [31:0]        seed, r;
  logic [31:0]        rd_q[$], pv_q[$];
  logic [12:0]        lv_tab[6];
  pvc_bus_type        bus;
  pvc_input_type      input_class;
  int                 failures, checks_done, on_cnt;

  pvc_stage #(.TICKS_PER_MS(2)) i_dut (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
    .input_class(input_class), .has_fraction(has_fraction), .unit_change_confirm(ucc),
    .two_output(two_output), .ssr_drive(ssr_drive), .self_tuning(self_tuning),
    .ramp_active(ramp_active), .reset_state(reset_state), .on_off(on_off),
    .input_error(input_error), .sample_valid(sample_valid), .sample(sample),
    .set_value(set_value), .demand1(demand1), .demand2(demand2), .pv(pv),
    .deviation1(deviation1), .deviation2(deviation2), .dp_pos(dp_pos),
    .short_digit(short_digit), .junction_comp_mode(jcm), .reinit(rinit), .level1(level1),
    .level2(lv2), .first_drive_channel(drv1), .second_drive_channel(drv2));

  pvc_sensor_model i_conv (.clk(clk), .start(start), .value(value), .drive(drv1),
    .clr(clr), .sample_valid(sample_valid), .sample(sample), .on_cnt(on_cnt));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 16'h0000};
    rd_q.push_back({16'h0000, e});
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic feed(input logic [15:0] v, input logic [31:0] e);
    @(posedge clk);
    start <= 1'b1;
    value <= v;
    pv_q.push_back(e);
    @(posedge clk);
    start <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Results answer one cycle after their strobe
  always @(posedge clk) begin
    rd_d <= bus.rd;
    sv_d <= sample_valid;
    if (rd_d) check(rdata, rd_q.pop_front());
    if (sv_d) check(pv, pv_q.pop_front());
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    {reset, two_output} = 2'b11;
    {has_fraction, ucc, ssr_drive, self_tuning, ramp_active} = '0;
    {reset_state, on_off, input_error, start, clr, rd_d, sv_d} = '0;
    {failures, checks_done} = '0;
    bus = '0;
    value = 16'h0000;
    set_value = 32'sd2000;
    demand1 = 10'd250;
    demand2 = 10'd100;
    input_class = PVC_IN_MV;
    seed = 32'h3272;
    lv_tab = '{{3'b100, 10'd600}, {3'b110, 10'd600}, {3'b010, 10'd300},
               {3'b011, 10'd0}, {3'b111, 10'd1000}, {3'b000, 10'd250}};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(OFF_CTRL, 16'h0081);
    rd(OFF_BIAS, 16'h0000);
    rd(OFF_FILT, 16'h0000);
    rd(OFF_SLOPE, 16'd1000);
    rd(OFF_LOWCUT, 16'd10);
    rd(OFF_RST1, 16'h0000);
    rd(OFF_ERR1, 16'h0000);
    rd(OFF_CYC1, 16'd30);
    rd(OFF_CYC2, 16'd30);
    rd(4'he, 16'h0000);
    wr(OFF_BIAS, 16'd5);
    wr(OFF_BIAS, 16'd10001);
    rd(OFF_BIAS, 16'd5);
    feed(16'd1234, 32'd1239);
    rd(OFF_PV_LO, 16'd1239);
    rd(OFF_PV_HI, 16'h0000);
    check(deviation1, 32'd761);
    check(deviation2, -32'sd761);
    wr(OFF_SLOPE, 16'd1500);
    wr(OFF_SLOPE, 16'd1501);
    rd(OFF_SLOPE, 16'd1500);
    feed(16'd1000, 32'd1505);
    wr(OFF_CTRL, 16'h00a1);
    feed(16'd400, 32'd3005);
    wr(OFF_SLOPE, 16'd1000);
    wr(OFF_BIAS, 16'd0);
    feed(16'd100, 32'd0);
    feed(16'd101, 32'd1004);
    wr(OFF_CTRL, 16'h0081);
    feed(16'd50, 32'd50);
    wr(OFF_LOWCUT, 16'd51);
    rd(OFF_LOWCUT, 16'd10);
    input_class <= PVC_IN_TC;
    wr(OFF_SLOPE, 16'd700);
    rd(OFF_SLOPE, 16'd1000);
    wr(OFF_CTRL, 16'h0094);
    @(negedge clk);
    check(dp_pos, 32'd1);
    check(jcm, 32'd1);
    input_class <= PVC_IN_MV;
    wr(OFF_CTRL, 16'h0084);
    @(negedge clk);
    check(dp_pos, 32'd4);
    wr(OFF_CTRL, 16'h0081);
    self_tuning <= 1'b1;
    wr(OFF_CTRL, 16'h00c1);
    rd(OFF_CTRL, 16'h0081);
    wr(OFF_CYC1, 16'd5);
    rd(OFF_CYC1, 16'd30);
    self_tuning <= 1'b0;
    ramp_active <= 1'b1;
    wr(OFF_CYC1, 16'd5);
    rd(OFF_CYC1, 16'd30);
    ramp_active <= 1'b0;
    wr(OFF_CYC1, 16'd1);
    wr(OFF_CYC1, 16'd121);
    rd(OFF_CYC1, 16'd1);
    wr(OFF_RST1, 16'd600);
    wr(OFF_RST1, 16'd1001);
    wr(OFF_ERR1, 16'd300);
    rd(OFF_RST1, 16'd600);
    foreach (lv_tab[i]) begin
      {reset_state, input_error, on_off} <= lv_tab[i][12:10];
      feed(16'd500, 32'd500);
      check(level1, lv_tab[i][9:0]);
    end
    rd(OFF_STAT, 16'h0003);
    wait (drv1 === 1'b1);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (4001) @(posedge clk);
    check(32'(on_cnt >= 998 && on_cnt <= 1002), 32'd1);
    check(drv2, 32'd1);
    check(lv2, 32'd100);
    two_output <= 1'b0;
    repeat (2) @(posedge clk);
    check(lv2, 32'd0);
    check(drv2, 32'd0);
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      r = seed % 10000;
      feed(r[15:0], r);
    end
    feed(16'd2002, 32'd2002);
    wr(OFF_FILT, 16'd101);
    rd(OFF_FILT, 16'h0000);
    wr(OFF_FILT, 16'd100);
    rd(OFF_FILT, 16'd100);
    feed(16'd0, 32'd2000);
    input_class <= PVC_IN_RTD;
    has_fraction <= 1'b1;
    wr(OFF_CTRL, 16'h0089);
    @(negedge clk);
    check(short_digit, 32'd1);
    check(rinit, 32'd1);
    wr(OFF_BIAS, 16'd7);
    @(posedge clk);
    ucc <= 1'b1;
    @(posedge clk);
    ucc <= 1'b0;
    repeat (2) @(posedge clk);
    rd(OFF_BIAS, 16'h0000);
    rd(OFF_FILT, 16'h0000);
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
